// *** design/rpsec_pkg.sv ***
// Constants, types and helpers for the per-port address security block.
// Assumes byte-wide frame streams with start/end markers from the repeater core.
// Notes on behaviour
// - With inbound protection, a source address unlike the permitted one is an intrusion.
// - Assigned or first-heard addresses: an intrusion disables the port automatically.
// - Continuous learning never disables the port on an address mismatch.
// - A disabled port stays disabled until management re-enables it.
// - Frames with a failed check sequence never count as a violation.
// - With alarms on, intrusions and newly seen addresses raise an alarm event.
// - Outbound protection passes unicast frames unaltered only to the permitted address.
// - Other unicast frames still go out with an alternating one-zero data field.
// - Multicast and broadcast frames always pass unmodified.
// - Substituted frames keep carrier activity and show as check-sequence errors.
// - First-heard mode captures the first frame's source address as permitted.
// - Continuous learning adopts each new source address as the permitted one.
// - A directly assigned address takes effect at once.
package rpsec_pkg;

  localparam int ADDR_W = 48;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 16;
  // Frame byte offsets; the counter saturates above the data start
  localparam logic [3:0] OFS_DA_END = 4'h6;
  localparam logic [3:0] OFS_SA = 4'h6;
  localparam logic [3:0] OFS_SA_END = 4'hc;
  localparam logic [3:0] OFS_DATA = 4'he;
  localparam logic [3:0] CNT_MAX = 4'hf;
  localparam int MCAST_BIT = 40;
  // Alternating one-zero fill byte
  localparam logic [7:0] FILL_BYTE = 8'haa;
  localparam logic [47:0] ADDR_RST = 48'h0;

  // How the permitted station address is kept
  typedef enum logic [1:0] {
    MODE_ASSIGNED = 2'b00,
    MODE_FIRST = 2'b01,
    MODE_CONT = 2'b10
  } rpsec_mode_type;

  // Full-width station address comparison
  function automatic logic rpsec_differs(input logic [47:0] a, input logic [47:0] b);
    rpsec_differs = (a != b);
  endfunction

endpackage

// *** design/rpsec_stream_if.sv ***
// Valid/ready byte stream carrier between the security logic and its FIFO.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ns
interface rpsec_stream_if #(parameter int W = 10);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface // rpsec_stream_if

// *** design/rpsec_fifo.sv ***
// Synchronous FIFO with registered full and empty flags.
// Assumes the source holds valid and data until ready is seen.
`timescale 1ns/1ns
module rpsec_fifo
  import rpsec_pkg::*;
#(
  parameter int W     = 10,
  parameter int DEPTH = FIFO_DEPTH
)(
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   reset_i,
  // Stream sides
  rpsec_stream_if.dst in_s,
  rpsec_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          full;
  logic          empty;
  logic          do_push;
  logic          do_pop;
  logic [AW:0]   next_count;

  assign do_push = in_s.valid && !full;
  assign do_pop = !empty && out_s.ready;
  assign in_s.ready = !full; // Registered flag, so no path from the sink
  assign out_s.valid = !empty;
  assign out_s.data = mem[rd_ptr];

  // Occupancy next value
  always_comb
  begin
    next_count = count;
    if (do_push && !do_pop)
      next_count = count + 1'b1;
    else if (do_pop && !do_push)
      next_count = count - 1'b1;
  end

  // Storage write
  always_ff @(posedge clk_i)
  begin
    if (do_push)
      mem[wr_ptr] <= in_s.data;
  end

  // Pointers and flags
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      full <= 1'b0;
      empty <= 1'b1;
    end
    else
    begin
      if (do_push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (do_pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= next_count;
      full <= (next_count == (AW+1)'(DEPTH));
      empty <= (next_count == '0);
    end
  end

endmodule // rpsec_fifo

// *** design/rpsec_port.sv ***
// Per-port address security: inbound intrusion check, outbound fill substitution.
// Assumes the core flags the final four check-sequence bytes and reports check status at end of frame.
`timescale 1ns/1ns
module rpsec_port
  import rpsec_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Management configuration
  input  wire logic        inbound_en_i,
  input  wire logic        outbound_en_i,
  input  wire logic        alarm_en_i,
  input  wire logic [1:0]  addr_mode_i,
  input  wire logic [47:0] assign_addr_i,
  input  wire logic        assign_stb_i,
  input  wire logic        reenable_i,
  // Received frame from the station
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_sof_i,
  input  wire logic        rx_eof_i,
  input  wire logic        rx_fcs_ok_i,
  // Outbound frame from the core
  input  wire logic        tx_in_valid_i,
  input  wire logic [7:0]  tx_in_data_i,
  input  wire logic        tx_in_sof_i,
  input  wire logic        tx_in_eof_i,
  input  wire logic        tx_in_fcs_i,
  output logic             tx_in_ready_o,
  // Outbound frame toward the station
  output logic             tx_out_valid_o,
  output logic [7:0]       tx_out_data_o,
  output logic             tx_out_sof_o,
  output logic             tx_out_eof_o,
  input  wire logic        tx_out_ready_i,
  // Status toward management
  output logic             port_enabled_o,
  output logic             addr_valid_o,
  output logic [47:0]      permitted_station_address_o,
  output logic             intrusion_o,
  output logic             new_addr_o,
  output logic             alarm_o
);

  rpsec_stream_if #(.W(10)) push_s ();
  rpsec_stream_if #(.W(10)) pop_s ();

  logic [3:0]  rx_cnt;
  logic [3:0]  rx_idx;
  logic [47:0] src_addr;
  logic        rx_good_eof;
  logic        rx_mismatch;
  logic        is_intrusion;
  logic        is_learn;
  logic [3:0]  tx_cnt;
  logic [3:0]  tx_idx;
  logic [47:0] dst_addr;
  logic        fill_q;
  logic        fill_now;
  logic        do_push;
  logic [7:0]  out_byte;

  // Inbound byte position; sof restarts the count
  assign rx_idx = rx_sof_i ? 4'h0 : rx_cnt;
  assign rx_good_eof = rx_valid_i && rx_eof_i && rx_fcs_ok_i;
  assign rx_mismatch = rpsec_differs(src_addr, permitted_station_address_o);
  assign is_intrusion = rx_good_eof && inbound_en_i && addr_valid_o && rx_mismatch
                        && (addr_mode_i != MODE_CONT);
  // Learning adopts first-heard or any new address in continuous mode
  assign is_learn = rx_good_eof && !assign_stb_i
                    && (((addr_mode_i == MODE_FIRST) && !addr_valid_o)
                        || ((addr_mode_i == MODE_CONT) && (rx_mismatch || !addr_valid_o)));

  // Inbound position counter
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      rx_cnt <= 4'h0;
    else if (rx_valid_i)
      rx_cnt <= (rx_idx == CNT_MAX) ? CNT_MAX : rx_idx + 4'h1;
  end

  // Source address capture, all 48 bits
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      src_addr <= ADDR_RST;
    else if (rx_valid_i && rx_idx >= OFS_SA && rx_idx < OFS_SA_END)
      src_addr <= {src_addr[39:0], rx_data_i};
  end

  // Permitted address: assignment wins over learning in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      permitted_station_address_o <= ADDR_RST;
      addr_valid_o <= 1'b0;
    end
    else if (assign_stb_i)
    begin
      permitted_station_address_o <= assign_addr_i;
      addr_valid_o <= 1'b1;
    end
    else if (is_learn)
    begin
      permitted_station_address_o <= src_addr;
      addr_valid_o <= 1'b1;
    end
  end

  // Port enable: intrusion disable wins over a same-cycle re-enable
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      port_enabled_o <= 1'b1;
    else if (is_intrusion)
      port_enabled_o <= 1'b0;
    else if (reenable_i)
      port_enabled_o <= 1'b1;
  end

  // Event pulses toward management; delivery to a manager is firmware's job
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      intrusion_o <= 1'b0;
      new_addr_o <= 1'b0;
      alarm_o <= 1'b0;
    end
    else
    begin
      intrusion_o <= rx_good_eof && inbound_en_i && addr_valid_o && rx_mismatch;
      new_addr_o <= is_learn;
      alarm_o <= alarm_en_i && ((rx_good_eof && inbound_en_i && addr_valid_o && rx_mismatch)
                                || is_learn);
    end
  end

  // Outbound position and fill decision at the first data byte
  assign tx_idx = tx_in_sof_i ? 4'h0 : tx_cnt;
  assign do_push = tx_in_valid_i && push_s.ready;
  assign fill_now = (tx_idx == OFS_DATA)
                    ? (outbound_en_i && addr_valid_o && !dst_addr[MCAST_BIT]
                       && rpsec_differs(dst_addr, permitted_station_address_o))
                    : (fill_q && tx_idx > OFS_DATA);
  // Fill only data bytes; header and check sequence are kept, so the station sees a bad check
  assign out_byte = (fill_now && !tx_in_fcs_i) ? FILL_BYTE : tx_in_data_i;

  // Outbound position counter, stalls with the FIFO
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      tx_cnt <= 4'h0;
    else if (do_push)
      tx_cnt <= (tx_idx == CNT_MAX) ? CNT_MAX : tx_idx + 4'h1;
  end

  // Destination address and held fill decision
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      dst_addr <= ADDR_RST;
      fill_q <= 1'b0;
    end
    else if (do_push)
    begin
      if (tx_idx < OFS_DA_END)
        dst_addr <= {dst_addr[39:0], tx_in_data_i};
      fill_q <= fill_now;
    end
  end

  // Every byte goes out, one for one, so carrier activity is unchanged
  assign push_s.valid = tx_in_valid_i;
  assign push_s.data = {tx_in_sof_i, tx_in_eof_i, out_byte};
  assign tx_in_ready_o = push_s.ready;
  assign pop_s.ready = tx_out_ready_i;
  assign tx_out_valid_o = pop_s.valid;
  assign tx_out_sof_o = pop_s.data[9];
  assign tx_out_eof_o = pop_s.data[8];
  assign tx_out_data_o = pop_s.data[7:0];

  // Output buffer; a slow station back-pressures the core
  rpsec_fifo #(
    .W     (10),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .in_s    (push_s),
    .out_s   (pop_s)
  );

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence seq_good_frame;
    rx_valid_i && rx_eof_i && rx_fcs_ok_i && inbound_en_i && addr_valid_o && rx_mismatch;
  endsequence
  sequence seq_disabling;
    seq_good_frame ##0 (addr_mode_i != MODE_CONT);
  endsequence
  sequence seq_assign_applied;
    addr_valid_o && permitted_station_address_o == $past(assign_addr_i);
  endsequence

  AST_INTRUSION_FLAG: assert property (seq_good_frame |=> intrusion_o)
    else $error("Mismatched source did not flag an intrusion");
  AST_INTRUDE_DISABLE: assert property (seq_disabling |=> !port_enabled_o)
    else $error("Intrusion did not disable the port");
  AST_CONT_KEEPS_PORT: assert property ((port_enabled_o && addr_mode_i == MODE_CONT) |=> port_enabled_o)
    else $error("Continuous learning port was disabled");
  AST_STAY_DISABLED: assert property ((!port_enabled_o && !reenable_i) |=> !port_enabled_o)
    else $error("Disabled port came back without re-enable");
  AST_BAD_FCS_QUIET: assert property ((rx_valid_i && rx_eof_i && !rx_fcs_ok_i) |=> !intrusion_o)
    else $error("Bad check sequence counted as violation");
  AST_ALARM_EVENT: assert property ((intrusion_o || new_addr_o) && $past(alarm_en_i) |-> alarm_o)
    else $error("Event without alarm");
  AST_MCAST_CLEAR: assert property ((do_push && fill_now) |-> !dst_addr[MCAST_BIT])
    else $error("Group frame was filled");
  AST_FILL_BYTE: assert property ((do_push && fill_now && !tx_in_fcs_i) |-> push_s.data[7:0] == FILL_BYTE)
    else $error("Fill byte wrong");
  AST_HEADER_KEPT: assert property ((do_push && tx_idx < OFS_DATA) |-> push_s.data[7:0] == tx_in_data_i)
    else $error("Header byte altered");
  AST_ASSIGN_NOW: assert property (assign_stb_i |=> seq_assign_applied)
    else $error("Assigned address not applied");

endmodule // rpsec_port

// *** tb/rpsec_station.sv ***
// End-station model on one repeater port: sends frames in, drains outbound bytes.
// Assumes the bench calls send between its own checks and reads got between frames.
`timescale 1ns/1ns
module rpsec_station (
  // Clock
  input  wire logic       clk_i,
  // Frames toward the port
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            rx_sof_o,
  output logic            rx_eof_o,
  output logic            rx_fcs_ok_o,
  // Outbound bytes from the port; mode 0 prompt, 1 slow, 2 stalled
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_sof_i,
  input  wire logic       tx_eof_i,
  input  wire logic [1:0] mode_i,
  output logic            tx_ready_o
);
  // Accepted beats as {sof, eof, byte}, so frame markers are judged too
  logic [9:0] got[$];
  logic       tick;

  initial
  begin
    {rx_valid_o, rx_sof_o, rx_eof_o, rx_fcs_ok_o, tick} = '0;
    rx_data_o  = 8'h00;
    tx_ready_o = 1'b1;
  end

  // Take a byte only at an edge where both sides agree, then retime ready
  always @(posedge clk_i)
  begin
    if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1)
      got.push_back({tx_sof_i, tx_eof_i, tx_data_i});
    #1;
    tick = ~tick;
    tx_ready_o = (mode_i == 2'b10) ? 1'b0 : (mode_i == 2'b01) ? tick : 1'b1;
  end

  // One byte per cycle, no gaps; the check status rides with the last byte
  task automatic send(input logic [175:0] f, input logic ok);
    @(posedge clk_i); // Idle edge first, so back-to-back calls never re-drive valid in one step
    #1;
    for (int i = 0; i < 22; i++)
    begin
      rx_valid_o  = 1'b1;
      rx_data_o   = f[175-8*i -: 8];
      rx_sof_o    = (i == 0);
      rx_eof_o    = (i == 21);
      rx_fcs_ok_o = ok;
      @(posedge clk_i);
      #1;
    end
    {rx_valid_o, rx_sof_o, rx_eof_o} = '0;
    rx_data_o   = ~rx_data_o; // Idle line never shows the stale byte
    rx_fcs_ok_o = ~ok;
  endtask
endmodule // rpsec_station

// *** tb/tb_top.sv ***
// Self-checking bench for one secured repeater port.
// Assumes the station model stands on the port side and the bench acts as core and management.
`timescale 1ns/1ns
module tb_top;
  import rpsec_pkg::*;
  logic        clk_i, reset_i, inb, outb, alm, stb, reen, txv, txs, txe, txf, txr, ov, en, av, intr, nw, al;
  logic        rxv, rxs, rxe, rxok, ordy, osof, oeof;
  logic [1:0]  mode, smode;
  logic [7:0]  rxd, txd, od;
  logic [47:0] aaddr, addr;
  int          error_cnt, checked;
  // A and B differ only in bit 0, A and C only in bit 47
  localparam logic [47:0] A = 48'h0000_1234_5678;
  localparam logic [47:0] B = 48'h0000_1234_5679;
  localparam logic [47:0] C = 48'h8000_1234_5678;

  rpsec_port rpsec_port_inst (.clk_i, .reset_i, .inbound_en_i(inb), .outbound_en_i(outb), .alarm_en_i(alm),
    .addr_mode_i(mode), .assign_addr_i(aaddr), .assign_stb_i(stb), .reenable_i(reen), .rx_valid_i(rxv),
    .rx_data_i(rxd), .rx_sof_i(rxs), .rx_eof_i(rxe), .rx_fcs_ok_i(rxok), .tx_in_valid_i(txv),
    .tx_in_data_i(txd), .tx_in_sof_i(txs), .tx_in_eof_i(txe), .tx_in_fcs_i(txf), .tx_in_ready_o(txr),
    .tx_out_valid_o(ov), .tx_out_data_o(od), .tx_out_sof_o(osof), .tx_out_eof_o(oeof), .tx_out_ready_i(ordy),
    .port_enabled_o(en), .addr_valid_o(av), .permitted_station_address_o(addr), .intrusion_o(intr),
    .new_addr_o(nw), .alarm_o(al));
  rpsec_station rpsec_station_inst (.clk_i, .rx_valid_o(rxv), .rx_data_o(rxd), .rx_sof_o(rxs),
    .rx_eof_o(rxe), .rx_fcs_ok_o(rxok), .tx_valid_i(ov), .tx_data_i(od), .tx_sof_i(osof), .tx_eof_i(oeof),
    .mode_i(smode), .tx_ready_o(ordy));

  // Free-running 100 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
    checked++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [175:0] frm(input logic [47:0] da, input logic [47:0] sa);
    return {da, sa, 16'h0004, 32'h0123_4567, 32'h89ab_cdef};
  endfunction

  task automatic rst();
    reset_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
  endtask

  task automatic t_assign(input logic [47:0] a);
    aaddr = a;
    stb = 1'b1;
    @(posedge clk_i);
    #1;
    stb = 1'b0;
    chk("addr valid", 48'h1, {47'h0, av});
    chk("address", a, addr);
  endtask

  // Core side: hold each byte until ready is seen at the edge
  task automatic push(input logic [175:0] f);
    for (int i = 0; i < 22; i++)
    begin
      {txv, txs, txe, txf} = {1'b1, i == 0, i == 21, i >= 18};
      txd = f[175-8*i -: 8];
      while (txr !== 1'b1)
      begin
        @(posedge clk_i);
        #1;
      end
      @(posedge clk_i);
      #1;
    end
    {txv, txs, txe, txf} = '0;
    txd = ~txd;
  endtask

  task automatic expect_out(input logic [175:0] f, input logic fill);
    logic [9:0] exp_b;
    for (int i = 0; i < 300 && rpsec_station_inst.got.size() < 22; i++)
      @(posedge clk_i);
    #1;
    chk("length", 48'd22, 48'(rpsec_station_inst.got.size()));
    // Markers ride with the first and last byte; only data bytes before the check sequence fill
    for (int i = 0; i < 22; i++)
    begin
      exp_b = {i == 0, i == 21, (fill && i >= 14 && i < 18) ? FILL_BYTE : f[175-8*i -: 8]};
      chk("byte", {38'h0, exp_b}, {38'h0, rpsec_station_inst.got[i]});
    end
  endtask

  task automatic t_inbound();
    rst();
    chk("enabled after reset", 48'h1, {47'h0, en});
    t_assign(A);
    {inb, alm, mode} = 4'b1100; // Inbound protection and alarms on, assigned-address mode
    rpsec_station_inst.send(frm(B, A), 1'b1);
    chk("intrusion", 48'h0, {47'h0, intr});
    rpsec_station_inst.send(frm(A, B), 1'b1);
    chk("intrusion", 48'h1, {47'h0, intr});
    chk("alarm", 48'h1, {47'h0, al});
    chk("enabled", 48'h0, {47'h0, en});
    rpsec_station_inst.send(frm(B, A), 1'b1);
    chk("still disabled", 48'h0, {47'h0, en});
    reen = 1'b1;
    @(posedge clk_i);
    #1;
    reen = 1'b0;
    chk("reenabled", 48'h1, {47'h0, en});
    rpsec_station_inst.send(frm(A, C), 1'b0);
    chk("bad check intrusion", 48'h0, {47'h0, intr});
    chk("bad check enabled", 48'h1, {47'h0, en});
    alm = 1'b0;
    rpsec_station_inst.send(frm(A, C), 1'b1);
    chk("quiet alarm", 48'h0, {47'h0, al});
  endtask

  // First-heard then continuous learning
  task automatic t_learn();
    for (int m = 1; m < 3; m++)
    begin
      rst();
      {inb, alm} = 2'b11;
      mode = m[1:0];
      rpsec_station_inst.send(frm(A, C), 1'b1);
      chk("learned", C, addr);
      chk("new addr", 48'h1, {47'h0, nw});
      rpsec_station_inst.send(frm(A, B), 1'b1);
      chk("enabled", {47'h0, m == 2}, {47'h0, en});
      chk("address", (m == 2) ? B : C, addr);
    end
  endtask

  task automatic t_out();
    logic [47:0] das[4];
    das = '{A, B, 48'h0100_0000_0001, 48'hffff_ffff_ffff};
    rst();
    t_assign(A);
    outb = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      rpsec_station_inst.got.delete();
      smode = {1'b0, k[0]};
      push(frm(das[k], C));
      expect_out(frm(das[k], C), k == 1);
    end
    // Station stalls until the buffer refuses, then drains it empty
    rpsec_station_inst.got.delete();
    smode = 2'b10;
    fork
      push(frm(A, C));
      begin
        repeat (40) @(posedge clk_i);
        #1;
        chk("ready when full", 48'h0, {47'h0, txr});
        chk("held", 48'h0, 48'(rpsec_station_inst.got.size()));
        smode = 2'b00;
      end
    join
    expect_out(frm(A, C), 1'b0);
    chk("drained", 48'h0, {47'h0, ov});
  endtask

  // Main sequence
  initial
  begin
    reset_i = 1'b1;
    {inb, outb, alm, stb, reen, txv, txs, txe, txf} = '0;
    {mode, smode, txd, aaddr, error_cnt, checked} = '0;
    t_inbound();
    t_learn();
    t_out();
    test_done();
  end

  // Watchdog far beyond the few hundred cycles the run needs
  initial
  begin
    #500000;
    error_cnt++;
    test_done();
  end
endmodule // tb_top
